//--- paux_top.sv
// aux switch control: vbus supply enable, charger pull-ups, audio switches, refclk select
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
module paux_top
  import paux_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // pins from outside
  input  wire logic        chip_reset_n_pin_i,
  input  wire logic        core_supply_present_i,
  input  wire logic [2:0]  ref_freq_select_pins_i,
  // line state from the receivers
  input  wire logic [1:0]  line_state_i,
  input  wire logic [1:0]  uart_data_i,
  // outputs to analog and pads
  output logic             vbus_supply_enable_out_o,
  output logic             dp_pullup_en_o,
  output logic             dm_pullup_en_o,
  output logic             dp_switch_en_o,
  output logic             dm_switch_en_o,
  output logic             se_rx_enable_o,
  output logic [1:0]       regulator_level_o,
  output logic [1:0]       data_low_bits_o,
  output logic [3:0]       ref_code_o
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic       rst_pin;
  logic       core_ok;
  logic [2:0] ref_freq_select_pins_sync;

  // reset pin: gates the pull-ups and forces the audio switches
  paux_sync #(.WIDTH(1)) u_sync_rst (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (chip_reset_n_pin_i),
    .sync_o    (rst_pin)
  );

  // core supply presence: an unpowered core cannot hold the switches open
  paux_sync #(.WIDTH(1)) u_sync_core (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (core_supply_present_i),
    .sync_o    (core_ok)
  );

  // reference straps: read only at pll start, sync keeps that sample clean
  paux_sync #(.WIDTH(3)) u_sync_ref (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (ref_freq_select_pins_i),
    .sync_o    (ref_freq_select_pins_sync)
  );

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [7:0] otg_ctrl;
    logic [7:0] io_pwr;
    logic [7:0] carkit;
    logic [7:0] mode;
    logic       uart_prev;
    logic [7:0] rdata;
    logic       vbus_en;
    logic       dp_pu;
    logic       dm_pu;
    logic       dp_sw;
    logic       dm_sw;
    logic       se_rx;
    logic [1:0] reg_lvl;
    logic [1:0] data_lo;
    logic [3:0] ref_code;
  } paux_st_t;

  // every flop of this module lives in this one struct; the synchronisers and ref decoder keep their own
  paux_st_t  st;
  paux_st_t  next_st;
  paux_ref_t ref_code;
  logic      pll_start;

  // ==========================================================
  // named register fields
  // ==========================================================
  logic       drive_vbus_internal_bit;
  logic       drive_vbus_external_bit;
  logic       dp_charger_pullup_bit;
  logic       dm_charger_pullup_bit;
  logic [1:0] uart_regulator_level_field;
  logic       left_speaker_switch_bit;
  logic       right_speaker_switch_bit;
  logic       microphone_switch_bit;
  logic       uart_mode_bit;
  logic       uart_entry;

  // otg control: either drive bit may request the supply
  assign drive_vbus_internal_bit    = st.otg_ctrl[PAUX_DRV_INT_POS];
  assign drive_vbus_external_bit    = st.otg_ctrl[PAUX_DRV_EXT_POS];

  // io and power management: pull-up requests, uart regulator level
  assign dp_charger_pullup_bit      = st.io_pwr[PAUX_DP_PU_POS];
  assign dm_charger_pullup_bit      = st.io_pwr[PAUX_DM_PU_POS];
  assign uart_regulator_level_field = st.io_pwr[PAUX_UREG_POS +: PAUX_UREG_W];

  // carkit control: audio routing requests
  assign left_speaker_switch_bit    = st.carkit[PAUX_SPK_L_POS];
  assign right_speaker_switch_bit   = st.carkit[PAUX_SPK_R_POS];
  assign microphone_switch_bit      = st.carkit[PAUX_MIC_POS];

  // uart entry is the first cycle in which the mode bit reads high
  assign uart_mode_bit              = st.mode[PAUX_UART_POS];
  assign uart_entry                 = uart_mode_bit & ~st.uart_prev;

  // ==========================================================
  // per-line charger pull-up gating
  // ==========================================================
  logic [1:0] pullup_req;
  logic [1:0] pullup_level;

  // index 0 is dp, index 1 is dm; a held reset pin wins over software
  assign pullup_req = {dm_charger_pullup_bit, dp_charger_pullup_bit};
  for (genvar g = 0; g < 2; g++)
  begin : g_pullup
    assign pullup_level[g] = rst_pin & pullup_req[g];
  end

  // ==========================================================
  // register port decode
  // ==========================================================
  logic       wr_otg;
  logic       wr_io;
  logic       wr_kit;
  logic       wr_mode;
  logic [7:0] mode_wdata;
  logic [7:0] status_word;
  logic [7:0] ref_word;

  // write hits; status and ref code indices fall through and are ignored
  assign wr_otg  = reg_wr_i && (reg_addr_i == PAUX_OTG_CTRL_ADDR);
  assign wr_io   = reg_wr_i && (reg_addr_i == PAUX_IO_PWR_ADDR);
  assign wr_kit  = reg_wr_i && (reg_addr_i == PAUX_CARKIT_ADDR);
  assign wr_mode = reg_wr_i && (reg_addr_i == PAUX_MODE_ADDR);

  // pll start is a pulse, never stored, so that bit reads back 0
  assign mode_wdata = reg_wdata_i & 8'hF7;

  // read-only status word, supply enable in bit 0
  assign status_word[0]   = st.vbus_en;
  assign status_word[1]   = st.dp_pu;
  assign status_word[2]   = st.dm_pu;
  assign status_word[3]   = st.dp_sw;
  assign status_word[4]   = st.dm_sw;
  assign status_word[5]   = st.se_rx;
  assign status_word[7:6] = 2'h0;

  // read-only reference code word
  assign ref_word = {4'h0, st.ref_code};

  // pll start pulse: the pll go bit (bit 3) of the mode register is written high
  assign pll_start = reg_wr_i && (reg_addr_i == PAUX_MODE_ADDR)
                     && reg_wdata_i[PAUX_PLL_GO_POS];

  paux_ref_freq_select_pins u_ref_freq_select_pins (
    .sys_clk_i              (sys_clk_i),
    .arst_n_i               (arst_n_i),
    .pll_start_i            (pll_start),
    .input_clk_mode_i       (reg_wdata_i[PAUX_INCLK_POS]),
    .ref_freq_select_pins_i (ref_freq_select_pins_sync),
    .ref_code_o             (ref_code),
    .ref_khz_o              ()
  );

  // ==========================================================
  // next state
  // ==========================================================
  always_comb
  begin
    logic drv;
    logic dp_sw;
    logic dm_sw;
    logic uart;
    drv     = 1'b0;
    dp_sw   = 1'b0;
    dm_sw   = 1'b0;
    uart    = 1'b0;
    next_st = st;

    // register writes; no mode clears them, only reset
    if (wr_otg)
      next_st.otg_ctrl = reg_wdata_i;
    if (wr_io)
      next_st.io_pwr = reg_wdata_i;
    if (wr_kit)
      next_st.carkit = reg_wdata_i;
    if (wr_mode)
      next_st.mode = mode_wdata;

    // read data stands one cycle after the strobe, zero otherwise
    next_st.rdata = 8'h00;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        PAUX_OTG_CTRL_ADDR: next_st.rdata = st.otg_ctrl;
        PAUX_IO_PWR_ADDR:   next_st.rdata = st.io_pwr;
        PAUX_CARKIT_ADDR:   next_st.rdata = st.carkit;
        PAUX_MODE_ADDR:     next_st.rdata = st.mode;
        PAUX_STATUS_ADDR:   next_st.rdata = status_word;
        PAUX_REFFREQ_ADDR:  next_st.rdata = ref_word;
        default:            next_st.rdata = 8'h00;
      endcase
    end

    // external supply switch enable
    drv = drive_vbus_internal_bit | drive_vbus_external_bit;
    next_st.vbus_en = drv;

    // charger pull-ups gated by the reset pin
    next_st.dp_pu = pullup_level[0];
    next_st.dm_pu = pullup_level[1];

    // audio switches: forced on when the core is unpowered or held in reset
    if (!core_ok || !rst_pin)
    begin
      dp_sw = 1'b1;
      dm_sw = 1'b1;
    end
    else
    begin
      dp_sw = left_speaker_switch_bit;
      dm_sw = right_speaker_switch_bit | microphone_switch_bit;
    end
    next_st.dp_sw = dp_sw;
    next_st.dm_sw = dm_sw;
    next_st.se_rx = ~(dp_sw | dm_sw);

    // regulator level switches on uart entry, back to normal on exit
    uart = uart_mode_bit;
    next_st.uart_prev = uart;
    if (uart_entry)
      next_st.reg_lvl = uart_regulator_level_field;
    else if (!uart)
      next_st.reg_lvl = PAUX_UREG_NORMAL;

    // lowest data bits carry uart data instead of line state in uart mode
    next_st.data_lo = uart ? uart_data_i : line_state_i;

    // registered once more so the output comes straight from a flop
    next_st.ref_code = ref_code;
  end

  // ==========================================================
  // registers; all bits clear at power-on reset except the two audio switch enables, which set
  // ==========================================================
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      // registers to their power-on values
      st.otg_ctrl  <= PAUX_OTG_CTRL_RST;
      st.io_pwr    <= PAUX_IO_PWR_RST;
      st.carkit    <= PAUX_CARKIT_RST;
      st.mode      <= PAUX_MODE_RST;
      st.uart_prev <= 1'b0;
      st.rdata     <= 8'h00;
      // pad levels as with the pin held: switches on, all else off
      st.vbus_en   <= 1'b0;
      st.dp_pu     <= 1'b0;
      st.dm_pu     <= 1'b0;
      st.dp_sw     <= 1'b1;
      st.dm_sw     <= 1'b1;
      st.se_rx     <= 1'b0;
      st.reg_lvl   <= PAUX_UREG_NORMAL;
      st.data_lo   <= 2'h0;
      st.ref_code  <= PAUX_REF_52M;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs straight from flip-flops
  // ==========================================================
  assign reg_rdata_o              = st.rdata;
  assign vbus_supply_enable_out_o = st.vbus_en;
  assign dp_pullup_en_o           = st.dp_pu;
  assign dm_pullup_en_o           = st.dm_pu;
  assign dp_switch_en_o           = st.dp_sw;
  assign dm_switch_en_o           = st.dm_sw;
  assign se_rx_enable_o           = st.se_rx;
  assign regulator_level_o        = st.reg_lvl;
  assign data_low_bits_o          = st.data_lo;
  assign ref_code_o               = st.ref_code;

endmodule

//--- paux_pkg.sv
// package: register map, field positions, reset values and encodings for the aux switch block
package paux_pkg;

  // register offsets (word index on the plain register port)
  localparam logic [3:0] PAUX_OTG_CTRL_ADDR  = 4'h0;
  localparam logic [3:0] PAUX_IO_PWR_ADDR    = 4'h1;
  localparam logic [3:0] PAUX_CARKIT_ADDR    = 4'h2;
  localparam logic [3:0] PAUX_MODE_ADDR      = 4'h3;
  localparam logic [3:0] PAUX_STATUS_ADDR    = 4'h4;
  localparam logic [3:0] PAUX_REFFREQ_ADDR   = 4'h5;

  // otg control field positions
  localparam int PAUX_DRV_INT_POS = 0;
  localparam int PAUX_DRV_EXT_POS = 1;
  // io and power management field positions
  localparam int PAUX_DP_PU_POS   = 0;
  localparam int PAUX_DM_PU_POS   = 1;
  localparam int PAUX_UREG_POS    = 2;
  localparam int PAUX_UREG_W      = 2;
  // carkit control field positions
  localparam int PAUX_SPK_L_POS   = 0;
  localparam int PAUX_SPK_R_POS   = 1;
  localparam int PAUX_MIC_POS     = 2;
  // mode register field positions
  localparam int PAUX_UART_POS    = 0;
  localparam int PAUX_INCLK_POS   = 1;
  localparam int PAUX_LOWPWR_POS  = 2;
  localparam int PAUX_PLL_GO_POS  = 3;

  // reset values
  localparam logic [7:0] PAUX_OTG_CTRL_RST = 8'h00;
  localparam logic [7:0] PAUX_IO_PWR_RST   = 8'h00;
  localparam logic [7:0] PAUX_CARKIT_RST   = 8'h00;
  localparam logic [7:0] PAUX_MODE_RST     = 8'h00;
  localparam logic [1:0] PAUX_UREG_NORMAL  = 2'h0;

  // reference frequency codes and their values in kHz
  typedef enum logic [3:0] {
    PAUX_REF_52M   = 4'h0,
    PAUX_REF_38M4  = 4'h1,
    PAUX_REF_12M   = 4'h2,
    PAUX_REF_27M   = 4'h3,
    PAUX_REF_13M   = 4'h4,
    PAUX_REF_19M2  = 4'h5,
    PAUX_REF_26M   = 4'h6,
    PAUX_REF_24M   = 4'h7,
    PAUX_REF_60M   = 4'h8
  } paux_ref_t;

  localparam logic [15:0] PAUX_KHZ_52M   = 16'hCB20;
  localparam logic [15:0] PAUX_KHZ_38M4  = 16'h9600;
  localparam logic [15:0] PAUX_KHZ_12M   = 16'h2EE0;
  localparam logic [15:0] PAUX_KHZ_27M   = 16'h6978;
  localparam logic [15:0] PAUX_KHZ_13M   = 16'h32C8;
  localparam logic [15:0] PAUX_KHZ_19M2  = 16'h4B00;
  localparam logic [15:0] PAUX_KHZ_26M   = 16'h6590;
  localparam logic [15:0] PAUX_KHZ_24M   = 16'h5DC0;
  localparam logic [15:0] PAUX_KHZ_60M   = 16'hEA60;

endpackage

//--- paux_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module paux_sync
  import paux_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  // pin levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } paux_sync_st_t;

  paux_sync_st_t st;
  paux_sync_st_t next_st;

  // first stage feeds only the second stage
  always_comb
  begin
    next_st        = st;
    next_st.meta   = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_o = st.stable;

endmodule

//--- paux_ref_freq_select_pins.sv
// reference frequency decode from the select pins, latched at pll start
`timescale 1ns/100ps
module paux_ref_freq_select_pins
  import paux_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // control
  input  wire logic        pll_start_i,
  input  wire logic        input_clk_mode_i,
  input  wire logic [2:0]  ref_freq_select_pins_i,
  // result
  output paux_ref_t        ref_code_o,
  output logic [15:0]      ref_khz_o
);

  typedef struct packed {
    logic [2:0] pins;
    logic       inclk;
  } paux_ref_st_t;

  paux_ref_st_t st;
  paux_ref_st_t next_st;

  // pins are static straps: caught only on pll start, later wiggles ignored
  always_comb
  begin
    next_st = st;
    if (pll_start_i)
    begin
      next_st.pins  = ref_freq_select_pins_i;
      next_st.inclk = input_clk_mode_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  // decode table, pin 2 is the msb
  always_comb
  begin
    ref_code_o = PAUX_REF_52M;
    ref_khz_o  = PAUX_KHZ_52M;
    if (st.inclk)
    begin
      ref_code_o = PAUX_REF_60M;
      ref_khz_o  = PAUX_KHZ_60M;
    end
    else
    begin
      unique case (st.pins)
        3'h0: begin ref_code_o = PAUX_REF_52M;  ref_khz_o = PAUX_KHZ_52M;  end
        3'h1: begin ref_code_o = PAUX_REF_38M4; ref_khz_o = PAUX_KHZ_38M4; end
        3'h2: begin ref_code_o = PAUX_REF_12M;  ref_khz_o = PAUX_KHZ_12M;  end
        3'h3: begin ref_code_o = PAUX_REF_27M;  ref_khz_o = PAUX_KHZ_27M;  end
        3'h4: begin ref_code_o = PAUX_REF_13M;  ref_khz_o = PAUX_KHZ_13M;  end
        3'h5: begin ref_code_o = PAUX_REF_19M2; ref_khz_o = PAUX_KHZ_19M2; end
        3'h6: begin ref_code_o = PAUX_REF_26M;  ref_khz_o = PAUX_KHZ_26M;  end
        3'h7: begin ref_code_o = PAUX_REF_24M;  ref_khz_o = PAUX_KHZ_24M;  end
      endcase
    end
  end

endmodule

//--- paux_checker.sv
// checker: port-level assertions for the aux switch block
`timescale 1ns/100ps
module paux_checker
  import paux_pkg::*;
(
  // clock, reset and register port
  input wire logic       sys_clk_i,
  input wire logic       arst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // pins and outputs
  input wire logic       chip_reset_n_pin_i,
  input wire logic       core_supply_present_i,
  input wire logic       vbus_supply_enable_out_o,
  input wire logic       dp_pullup_en_o,
  input wire logic       dm_pullup_en_o,
  input wire logic       dp_switch_en_o,
  input wire logic       dm_switch_en_o,
  input wire logic       se_rx_enable_o,
  input wire logic [3:0] ref_code_o
);
  // ==========================================================
  // helpers: decoded writes, pins held steady long enough to sync
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic wr_otg = reg_wr_i && (reg_addr_i == PAUX_OTG_CTRL_ADDR);
  wire logic wr_io  = reg_wr_i && (reg_addr_i == PAUX_IO_PWR_ADDR);
  wire logic wr_kit = reg_wr_i && (reg_addr_i == PAUX_CARKIT_ADDR);
  wire logic start  = reg_wr_i && (reg_addr_i == PAUX_MODE_ADDR) && reg_wdata_i[3];
  wire logic up     = chip_reset_n_pin_i && core_supply_present_i;
  sequence s_wr_io;
    up[*4] ##0 wr_io ##1 up[*2];
  endsequence
  sequence s_wr_kit;
    up[*4] ##0 wr_kit ##1 up[*2];
  endsequence
  // ==========================================================
  // assertions
  AST_VBUS_OR: assert property (wr_otg |-> ##2
    (vbus_supply_enable_out_o == |$past(reg_wdata_i[1:0], 2))) else $error("vbus enable wrong");
  AST_PU_GATE: assert property (!chip_reset_n_pin_i[*4] |=>
    !dp_pullup_en_o && !dm_pullup_en_o) else $error("pull-up on while pin low");
  AST_PU_FOLLOW: assert property (s_wr_io |-> (dp_pullup_en_o == $past(reg_wdata_i[0], 2))
    && (dm_pullup_en_o == $past(reg_wdata_i[1], 2))) else $error("pull-up not following bit");
  AST_SW_FORCE: assert property ((!core_supply_present_i[*4]) or (!chip_reset_n_pin_i[*4])
    |=> dp_switch_en_o && dm_switch_en_o) else $error("audio switch not forced");
  AST_SW_FOLLOW: assert property (s_wr_kit |-> (dp_switch_en_o == $past(reg_wdata_i[0], 2))
    && (dm_switch_en_o == |$past(reg_wdata_i[2:1], 2))) else $error("audio switch wrong");
  AST_SE_OFF: assert property ((dp_switch_en_o || dm_switch_en_o)[*2] |->
    !se_rx_enable_o) else $error("receivers on with switch on");
  AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("stray read data");
  AST_RD_UNMAP: assert property (reg_rd_i && reg_addr_i > 4'h5 |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  AST_REF_60: assert property (start && reg_wdata_i[1] |-> ##2 ref_code_o == 4'h8)
    else $error("input clock mode code wrong");
  AST_REF_HOLD: assert property (!start[*4] |-> $stable(ref_code_o))
    else $error("ref code moved without start");
endmodule

bind paux_top paux_checker chk_u (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .chip_reset_n_pin_i(chip_reset_n_pin_i),
  .core_supply_present_i(core_supply_present_i),
  .vbus_supply_enable_out_o(vbus_supply_enable_out_o), .dp_pullup_en_o(dp_pullup_en_o),
  .dm_pullup_en_o(dm_pullup_en_o), .dp_switch_en_o(dp_switch_en_o),
  .dm_switch_en_o(dm_switch_en_o), .se_rx_enable_o(se_rx_enable_o), .ref_code_o(ref_code_o));

//--- paux_vbus_switch.sv
// partner model: external vbus power switch behind the supply enable
`timescale 1ns/100ps
module paux_vbus_switch
#(
  parameter int RISE_CYCLES = 1
)(
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  // enable from the device, rail state back
  input  wire logic enable_i,
  output logic      vbus_on_o
);
  int cnt;
  // ==========================================================
  // rail ramps after a settle time, drops at once on disable
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt <= 0;
    else if (!enable_i)
      cnt <= 0;
    else if (cnt < RISE_CYCLES)
      cnt <= cnt + 1;
  end
  assign vbus_on_o = enable_i && (cnt >= RISE_CYCLES);
endmodule

//--- tb.sv
// self-checking bench for the aux switch block
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb
  import paux_pkg::*;
;
  logic       clk, arst_n, wr, rd, pin_n, core, vbus, vbus_on, dp_pu, dm_pu, dp_sw, dm_sw, se;
  logic [3:0] addr, ref_code;
  logic [7:0] wdata, rdata;
  logic [2:0] refpins;
  logic [1:0] ls, ud, lvl, dlow;
  int         n_errors, tests_run;
  // ==========================================================
  // design, partner and clock
  paux_top dut_u (.sys_clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .chip_reset_n_pin_i(pin_n),
    .core_supply_present_i(core), .ref_freq_select_pins_i(refpins), .line_state_i(ls),
    .uart_data_i(ud), .vbus_supply_enable_out_o(vbus), .dp_pullup_en_o(dp_pu),
    .dm_pullup_en_o(dm_pu), .dp_switch_en_o(dp_sw), .dm_switch_en_o(dm_sw),
    .se_rx_enable_o(se), .regulator_level_o(lvl), .data_low_bits_o(dlow), .ref_code_o(ref_code));
  paux_vbus_switch vsw_u (.sys_clk_i(clk), .arst_n_i(arst_n), .enable_i(vbus), .vbus_on_o(vbus_on));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // bus tasks; strobes drop on the edge that samples them
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // ==========================================================
  // scenarios
  task automatic t_vbus;
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(PAUX_OTG_CTRL_ADDR, 8'(i));
      cyc(4);
      `CHK(vbus, |i[1:0])
      `CHK(vbus_on, |i[1:0])
    end
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    cyc(4);
    `CHK(vbus, 1'b0)
    rd_chk(PAUX_OTG_CTRL_ADDR, 8'h00);
    $display("vbus test done");
  endtask
  task automatic t_pullup;
    wr_reg(PAUX_IO_PWR_ADDR, 8'h01);
    cyc(3);
    `CHK({dp_pu, dm_pu}, 2'b10)
    wr_reg(PAUX_IO_PWR_ADDR, 8'h02);
    pin_n <= 1'b0;
    cyc(5);
    `CHK({dp_pu, dm_pu}, 2'b00)
    @(posedge clk);
    pin_n <= 1'b1;
    cyc(5);
    `CHK({dp_pu, dm_pu}, 2'b01)
    $display("pull-up test done");
  endtask
  task automatic t_audio;
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(PAUX_CARKIT_ADDR, 8'(i));
      cyc(3);
      `CHK({dp_sw, dm_sw}, {i[0], i[1] | i[2]})
      `CHK(se, i == 0)
    end
    wr_reg(PAUX_CARKIT_ADDR, 8'h00);
    core <= 1'b0;
    cyc(5);
    `CHK({dp_sw, dm_sw}, 2'b11)
    @(posedge clk);
    core <= 1'b1;
    pin_n <= 1'b0;
    cyc(5);
    `CHK({dp_sw, dm_sw}, 2'b11)
    @(posedge clk);
    pin_n <= 1'b1;
    cyc(5);
    `CHK({dp_sw, dm_sw}, 2'b00)
    $display("audio test done");
  endtask
  task automatic t_ref;
    for (int p = 0; p < 8; p++)
    begin
      @(posedge clk);
      refpins <= 3'(p);
      cyc(4);
      wr_reg(PAUX_MODE_ADDR, 8'h08);
      cyc(3);
      `CHK(ref_code, 4'(p))
    end
    @(posedge clk);
    refpins <= 3'h2;
    cyc(6);
    `CHK(ref_code, 4'h7)
    wr_reg(PAUX_MODE_ADDR, 8'h0A);
    cyc(3);
    `CHK(ref_code, 4'h8)
    rd_chk(PAUX_MODE_ADDR, 8'h02);
    wr_reg(PAUX_MODE_ADDR, 8'h00);
    $display("reference test done");
  endtask
  task automatic t_uart;
    ls <= 2'b01;
    ud <= 2'b10;
    wr_reg(PAUX_IO_PWR_ADDR, 8'h08);
    cyc(3);
    `CHK(dlow, 2'b01)
    wr_reg(PAUX_MODE_ADDR, 8'h01);
    cyc(3);
    `CHK(lvl, 2'h2)
    `CHK(dlow, 2'b10)
    wr_reg(PAUX_MODE_ADDR, 8'h05);
    rd_chk(PAUX_IO_PWR_ADDR, 8'h08);
    rd_chk(PAUX_MODE_ADDR, 8'h05);
    wr_reg(PAUX_MODE_ADDR, 8'h00);
    cyc(3);
    `CHK(lvl, 2'h0)
    wr_reg(4'hF, 8'hFF);
    rd_chk(4'hF, 8'h00);
    $display("uart test done");
  endtask
  // ==========================================================
  // verdict, watchdog and main sequence
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk);
    n_errors++;
    conclude();
  end
  initial
  begin
    {arst_n, wr, rd, refpins, ls, ud, addr, wdata} = '0;
    {pin_n, core} = 2'b11;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    cyc(4);
    `CHK({vbus, dp_sw, dm_sw, dp_pu}, 4'h0)
    rd_chk(PAUX_CARKIT_ADDR, 8'h00);
    t_vbus();
    t_pullup();
    t_audio();
    t_ref();
    t_uart();
    conclude();
  end
endmodule
